// [hw/sfr_defs.svh]
// Constants shared by both ends of the serial flash read link
`ifndef SFR_DEFS_SVH
`define SFR_DEFS_SVH

`define SFR_OP_FAST       8'h0B
`define SFR_OP_DOUT       8'h3B
`define SFR_OP_QOUT       8'h6B
`define SFR_OP_DADDR      8'hBB
`define SFR_OP_EXIT       8'hFF
`define SFR_CONT_NIB      4'hA
`define SFR_CFG_QE_BIT    1
`define SFR_CMD_CLKS      5'h08
`define SFR_ADDR1_CLKS    5'h18
`define SFR_ADDR2_CLKS    5'h0C
`define SFR_MODE_CLKS     5'h04
`define SFR_DUMMY_CLKS    5'h08
`define SFR_SHORT_CLKS    4'h8
`define SFR_MEM_AW        8
`define SFR_TOP_ADDR      24'h00_00FF
`define SFR_SCK_HALF      3'h4
`define SFR_GAP_TICKS     2'h2
`define SFR_FIFO_WIDTH    8
`define SFR_FIFO_DEPTH    32

`endif

// [hw/sfr_pkg.sv]
// Types shared by both ends of the serial flash read link
package sfr_pkg;

  typedef enum logic [5:0] {
    SFR_PH_CMD   = 6'h01,
    SFR_PH_ADDR  = 6'h02,
    SFR_PH_MODE  = 6'h04,
    SFR_PH_DUMMY = 6'h08,
    SFR_PH_DATA  = 6'h10,
    SFR_PH_IGN   = 6'h20
  } sfr_dev_phase_type;

  typedef enum logic [3:0] {
    SFR_K_FAST  = 4'h1,
    SFR_K_DOUT  = 4'h2,
    SFR_K_QOUT  = 4'h4,
    SFR_K_DADDR = 4'h8
  } sfr_kind_type;

  typedef enum logic [6:0] {
    SFR_H_IDLE  = 7'h01,
    SFR_H_CMD   = 7'h02,
    SFR_H_ADDR  = 7'h04,
    SFR_H_MODE  = 7'h08,
    SFR_H_DUMMY = 7'h10,
    SFR_H_DATA  = 7'h20,
    SFR_H_GAP   = 7'h40
  } sfr_host_phase_type;

endpackage

// [hw/sfr_link_if.sv]
// Serial flash link: clock, select and four shared data lanes
`timescale 1ns/10ps
interface sfr_link_if;
  logic       sck;
  logic       cs_b;
  logic [3:0] host_lane;
  logic [3:0] host_lane_oe_b;
  logic [3:0] dev_lane;
  logic [3:0] dev_lane_oe_b;
  logic [3:0] lane;

  // Lane 0 in, 1 out, 2 protect, 3 pause; undriven lanes pull high
  assign lane = (~dev_lane_oe_b & dev_lane) | (~host_lane_oe_b & host_lane) | (dev_lane_oe_b & host_lane_oe_b);

  modport host (
    output sck,
    output cs_b,
    output host_lane,
    output host_lane_oe_b,
    input  lane
  );

  modport device (
    input  sck,
    input  cs_b,
    input  lane,
    output dev_lane,
    output dev_lane_oe_b
  );
endinterface

// [hw/sfr_dev.sv]
// Flash device end: fast, two-lane and four-lane array reads
//
// What this block and the host end do
// RULE1: Opcode, 24-bit address, dummy sampled on rise.
// RULE2: Fast read data leaves lane1 on falling edge.
// RULE3: Any start address, advance per byte.
// RULE4: Address wraps to zero past top.
// RULE5: Raising select stops drive, ends command.
// RULE6: Reads while internally busy are ignored.
// RULE7: Two-lane output read drives lanes zero, one.
// RULE8: Four-lane output read drives all four lanes.
// RULE9: Host releases lanes before first data fall.
// RULE10: Four-lane read needs quad_enable bit one.
// RULE11: Two-lane address read takes address two-wide.
// RULE12: Only upper continuation nibble is decoded.
// RULE13: Nibble A keeps continuous mode, opcode skipped.
// RULE14: Other nibble leaves continuous mode next frame.
// RULE15: Short invalid frame leaves continuous mode.
// RULE16: Opcode 0B selects fast single-lane read.
// RULE17: Separate opcodes for two and four-lane reads.
`timescale 1ns/10ps
`include "sfr_defs.svh"

module sfr_dev (
  sfr_link_if.device       link,          // Link from host
  input  wire logic        rst_b_i,       // Async reset
  input  wire logic        ce_i,          // Clock enable
  input  wire logic        op_busy_i,     // Program or erase running
  input  wire logic [7:0]  config_reg_i,  // Configuration bits
  input  wire logic        wr_clk_i,      // Array load clock
  input  wire logic        wr_en_i,       // Array load strobe
  input  wire logic [7:0]  wr_addr_i,     // Array load address
  input  wire logic [7:0]  wr_data_i,     // Array load byte
  output logic             cont_mode_o,   // Continuous mode held
  output logic             ignored_o      // Last command refused
);
  import sfr_pkg::*;

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    sfr_dev_phase_type phase;
    sfr_kind_type      kind;
    logic [4:0]        cnt;
    logic [3:0]        clks;
    logic [23:0]       addr;
    logic [7:0]        byt;
    logic [2:0]        bpos;
  } sfr_frame_type;

  typedef struct packed {
    logic       cont;
    logic       ign;
    logic [3:0] last_clks;
    logic [1:0] busy_s;
    logic [1:0] qe_s;
  } sfr_keep_type;

  typedef struct packed {
    logic [3:0] lane;
    logic [3:0] oe_b;
  } sfr_drive_type;

  localparam sfr_frame_type FRAME_RST = '{
    phase: SFR_PH_CMD,
    kind:  SFR_K_FAST,
    default: '0
  };
  localparam sfr_drive_type DRIVE_RST = '{lane: 4'h0, oe_b: 4'hF};

  sfr_frame_type     fr_q;
  sfr_frame_type     fr_d;
  sfr_keep_type      kp_q;
  sfr_keep_type      kp_d;
  sfr_drive_type     dr_q;
  sfr_drive_type     dr_d;
  sfr_dev_phase_type ph;
  sfr_kind_type      kd;
  logic              first;
  logic              cont_ok;
  logic              load;
  logic [7:0]        op;
  logic [7:0]        sh;
  logic [2:0]        dstep;
  logic [2:0]        bnext;
  logic [3:0]        lin;

  logic [7:0] mem [0:(1 << `SFR_MEM_AW) - 1];

  // ---------------------------------------------------------------
  // Array storage
  // ---------------------------------------------------------------
  // Loaded from its own clock; reads during a load see either value
  always_ff @(posedge wr_clk_i) begin
    if (wr_en_i) begin
      mem[wr_addr_i] <= wr_data_i;
    end
  end

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    fr_d  = fr_q;
    kp_d  = kp_q;
    load  = 1'b0;
    lin   = link.lane;
    op    = {fr_q.addr[6:0], lin[0]};
    first = (fr_q.clks == 4'h0);
    kp_d.busy_s = {kp_q.busy_s[0], op_busy_i};
    kp_d.qe_s   = {kp_q.qe_s[0], config_reg_i[`SFR_CFG_QE_BIT]};

    // RULE15: short frame exits continuous
    cont_ok = kp_q.cont && (kp_q.last_clks > `SFR_SHORT_CLKS);

    ph = fr_q.phase;
    kd = fr_q.kind;
    if (first) begin
      kp_d.cont = cont_ok;
      kp_d.ign  = 1'b0;
      // RULE13: continuous frame starts at address
      if (cont_ok) begin
        kd = SFR_K_DADDR;
        ph = kp_q.busy_s[1] ? SFR_PH_IGN : SFR_PH_ADDR;
        // RULE6: refuse while busy
        if (kp_q.busy_s[1]) begin
          kp_d.ign = 1'b1;
        end
      end
    end
    fr_d.phase = ph;
    fr_d.kind  = kd;
    fr_d.clks  = (fr_q.clks == 4'hF) ? fr_q.clks : fr_q.clks + 4'h1;
    kp_d.last_clks = fr_d.clks;
    fr_d.cnt   = fr_q.cnt + 5'h01;

    unique case (kd)
      SFR_K_FAST: dstep = 3'h1;
      SFR_K_QOUT: dstep = 3'h4;
      default:    dstep = 3'h2;
    endcase
    bnext = fr_q.bpos + dstep;

    unique case (ph)
      SFR_PH_CMD: begin
        // RULE1: opcode sampled on lane0
        fr_d.addr = {fr_q.addr[22:0], lin[0]};
        if (fr_q.cnt == `SFR_CMD_CLKS - 5'h01) begin
          fr_d.cnt   = 5'h00;
          fr_d.addr  = 24'h00_0000;
          fr_d.phase = SFR_PH_ADDR;
          // RULE6: refuse while busy
          if (kp_q.busy_s[1]) begin
            fr_d.phase = SFR_PH_IGN;
            kp_d.ign   = 1'b1;
          // RULE16: fast read opcode
          end else if (op == `SFR_OP_FAST) begin
            fr_d.kind = SFR_K_FAST;
          // RULE17: multi-lane opcodes
          end else if (op == `SFR_OP_DOUT) begin
            fr_d.kind = SFR_K_DOUT;
          // RULE10: quad needs enable bit
          end else if (op == `SFR_OP_QOUT && kp_q.qe_s[1]) begin
            fr_d.kind = SFR_K_QOUT;
          end else if (op == `SFR_OP_DADDR) begin
            fr_d.kind = SFR_K_DADDR;
          end else begin
            fr_d.phase = SFR_PH_IGN;
            kp_d.ign   = 1'b1;
          end
        end
      end
      SFR_PH_ADDR: begin
        if (kd == SFR_K_DADDR) begin
          // RULE11: address two bits per clock
          fr_d.addr = {fr_q.addr[21:0], lin[1:0]};
          if (fr_q.cnt == `SFR_ADDR2_CLKS - 5'h01) begin
            fr_d.cnt   = 5'h00;
            fr_d.phase = SFR_PH_MODE;
          end
        end else begin
          // RULE1: address then dummy
          fr_d.addr = {fr_q.addr[22:0], lin[0]};
          if (fr_q.cnt == `SFR_ADDR1_CLKS - 5'h01) begin
            fr_d.cnt   = 5'h00;
            fr_d.phase = SFR_PH_DUMMY;
          end
        end
      end
      SFR_PH_MODE: begin
        fr_d.byt = {fr_q.byt[5:0], lin[1:0]};
        if (fr_q.cnt == `SFR_MODE_CLKS - 5'h01) begin
          load = 1'b1;
          // RULE12: upper nibble only
          // RULE14: any other nibble drops mode
          kp_d.cont = (fr_q.byt[5:2] == `SFR_CONT_NIB);
        end
      end
      SFR_PH_DUMMY: begin
        if (fr_q.cnt == `SFR_DUMMY_CLKS - 5'h01) begin
          load = 1'b1;
        end
      end
      SFR_PH_DATA: begin
        fr_d.bpos = bnext;
        // RULE3: next byte after a full one
        if (bnext == 3'h0) begin
          load = 1'b1;
        end
      end
      SFR_PH_IGN: begin
        fr_d.cnt = fr_q.cnt;
      end
      default: begin
        fr_d.phase = SFR_PH_IGN;
      end
    endcase

    if (load) begin
      fr_d.phase = SFR_PH_DATA;
      fr_d.byt   = mem[fr_q.addr[`SFR_MEM_AW-1:0]];
      fr_d.bpos  = 3'h0;
      // RULE4: wrap past top address
      fr_d.addr  = (fr_q.addr == `SFR_TOP_ADDR) ? 24'h00_0000 : fr_q.addr + 24'h00_0001;
    end

    // Output lanes, taken on the falling edge
    sh   = fr_q.byt << fr_q.bpos;
    dr_d = DRIVE_RST;
    if (fr_q.phase == SFR_PH_DATA) begin
      unique case (fr_q.kind)
        // RULE2: single lane on lane1
        SFR_K_FAST: begin
          dr_d.lane = {2'h0, sh[7], 1'b0};
          dr_d.oe_b = 4'hD;
        end
        // RULE8: four lanes, MSB on lane3
        SFR_K_QOUT: begin
          dr_d.lane = sh[7:4];
          dr_d.oe_b = 4'h0;
        end
        // RULE7: two lanes, MSB on lane1
        default: begin
          dr_d.lane = {2'h0, sh[7:6]};
          dr_d.oe_b = 4'hC;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  // RULE5: select high clears the frame
  always_ff @(posedge link.sck or negedge rst_b_i or posedge link.cs_b) begin
    if (!rst_b_i || link.cs_b) begin
      fr_q <= FRAME_RST;
    end else if (ce_i) begin
      fr_q <= fr_d;
    end
  end

  // Survives select high; sync flops only advance while sck runs
  always_ff @(posedge link.sck or negedge rst_b_i) begin
    if (!rst_b_i) begin
      kp_q <= '0;
    end else if (ce_i) begin
      kp_q <= kp_d;
    end
  end

  // RULE5: release lanes on select high
  always_ff @(negedge link.sck or negedge rst_b_i or posedge link.cs_b) begin
    if (!rst_b_i || link.cs_b) begin
      dr_q <= DRIVE_RST;
    end else if (ce_i) begin
      dr_q <= dr_d;
    end
  end

  assign link.dev_lane      = dr_q.lane;
  assign link.dev_lane_oe_b = dr_q.oe_b;
  assign cont_mode_o        = kp_q.cont;
  assign ignored_o          = kp_q.ign;

endmodule

// [hw/sfr_host.sv]
// Host end: read command sequencer with a receive FIFO
`timescale 1ns/10ps
`include "sfr_defs.svh"

module sfr_fifo #(
  parameter int WIDTH = `SFR_FIFO_WIDTH,
  parameter int DEPTH = `SFR_FIFO_DEPTH
) (
  input  wire logic             clk_i,        // System clock
  input  wire logic             rst_b_i,      // Async reset
  input  wire logic             ce_i,         // Clock enable
  input  wire logic             in_valid_i,   // Push request
  output logic                  in_ready_o,   // Room left
  input  wire logic [WIDTH-1:0] in_data_i,    // Push data
  output logic                  out_valid_o,  // Head valid
  input  wire logic             out_ready_i,  // Pop accept
  output logic [WIDTH-1:0]      out_data_o    // Head data
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW-1:0]    wp;
    logic [AW-1:0]    rp;
    logic [AW:0]      cnt;
    logic             ov;
    logic [WIDTH-1:0] od;
  } sfr_fifo_type;

  sfr_fifo_type     q;
  sfr_fifo_type     d;
  logic             push;
  logic             pop;
  logic [WIDTH-1:0] mem [0:DEPTH-1];

  assign in_ready_o  = (q.cnt != (AW+1)'(DEPTH));
  assign push        = in_valid_i && in_ready_o && ce_i;
  assign pop         = (q.cnt != '0) && (!q.ov || out_ready_i) && ce_i;
  assign out_valid_o = q.ov;
  assign out_data_o  = q.od;

  always_comb begin
    d = q;
    if (push) begin
      d.wp = q.wp + AW'(1);
    end
    // Registered head keeps the output straight from a flop
    if (pop) begin
      d.rp = q.rp + AW'(1);
      d.od = mem[q.rp];
      d.ov = 1'b1;
    end else if (out_ready_i) begin
      d.ov = 1'b0;
    end
    d.cnt = q.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[q.wp] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      q <= '0;
    end else if (ce_i) begin
      q <= d;
    end
  end
endmodule

module sfr_host (
  input  wire logic                  clk_i,          // System clock
  input  wire logic                  rst_b_i,        // Async reset
  input  wire logic                  ce_i,           // Clock enable
  sfr_link_if.host                   link,           // Link to device
  input  wire logic                  cmd_valid_i,    // Command request
  output logic                       cmd_ready_o,    // Idle, takes command
  input  wire sfr_pkg::sfr_kind_type cmd_kind_i,     // Read kind
  input  wire logic [23:0]           cmd_addr_i,     // Start address
  input  wire logic [7:0]            cmd_mode_i,     // Continuation byte
  input  wire logic                  cmd_skip_op_i,  // Omit opcode (DADDR), other kinds send exit frame
  input  wire logic [7:0]            cmd_len_i,      // Bytes, zero is 256
  output logic                       rd_valid_o,     // Read byte valid
  input  wire logic                  rd_ready_i,     // Read byte taken
  output logic [7:0]                 rd_data_o       // Read byte
);
  import sfr_pkg::*;

  typedef struct packed {
    sfr_host_phase_type phase;
    sfr_kind_type       kind;
    logic               exitf;
    logic [2:0]         div;
    logic               sck;
    logic               cs_b;
    logic [4:0]         cnt;
    logic [39:0]        tx;
    logic [7:0]         rx;
    logic [2:0]         bits;
    logic [7:0]         left;
    logic [3:0]         lane;
    logic [3:0]         oe_b;
    logic               ready;
    logic [3:0]         sync1;
    logic [3:0]         sync2;
    logic               push;
    logic [7:0]         pdat;
    logic [1:0]         gap;
  } sfr_host_type;

  localparam sfr_host_type HOST_RST = '{
    phase: SFR_H_IDLE,
    kind:  SFR_K_FAST,
    cs_b:  1'b1,
    oe_b:  4'hF,
    ready: 1'b1,
    default: '0
  };

  sfr_host_type q;
  sfr_host_type d;
  logic         fifo_ready;
  logic         tick;
  logic         dual_in;
  logic [7:0]   op;
  logic [7:0]   rxn;
  logic [2:0]   bn;

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  always_comb begin
    d       = q;
    d.push  = 1'b0;
    d.sync1 = link.lane;
    d.sync2 = q.sync1;
    // Back-pressure: sck holds low until the FIFO has room
    tick    = (q.div == `SFR_SCK_HALF - 3'h1) &&
              !(q.phase == SFR_H_DATA && !q.sck && !fifo_ready);
    if (q.div != `SFR_SCK_HALF - 3'h1) begin
      d.div = q.div + 3'h1;
    end else if (tick) begin
      d.div = 3'h0;
    end
    dual_in = (q.kind == SFR_K_DADDR) && (q.phase == SFR_H_ADDR || q.phase == SFR_H_MODE);
    unique case (cmd_kind_i)
      SFR_K_DOUT:  op = `SFR_OP_DOUT;
      // RULE10: caller must have set quad_enable
      SFR_K_QOUT:  op = `SFR_OP_QOUT;
      SFR_K_DADDR: op = `SFR_OP_DADDR;
      default:     op = `SFR_OP_FAST;
    endcase
    unique case (q.kind)
      SFR_K_FAST: begin
        rxn = {q.rx[6:0], q.sync2[1]};
        bn  = q.bits + 3'h1;
      end
      SFR_K_QOUT: begin
        rxn = {q.rx[3:0], q.sync2};
        bn  = q.bits + 3'h4;
      end
      default: begin
        rxn = {q.rx[5:0], q.sync2[1:0]};
        bn  = q.bits + 3'h2;
      end
    endcase

    if (q.phase == SFR_H_IDLE) begin
      if (cmd_valid_i) begin
        // RULE1: select low, opcode first
        d.ready = 1'b0;
        d.cs_b  = 1'b0;
        d.div   = 3'h0;
        d.cnt   = 5'h00;
        d.kind  = cmd_kind_i;
        d.left  = cmd_len_i;
        d.bits  = 3'h0;
        d.exitf = cmd_skip_op_i && (cmd_kind_i != SFR_K_DADDR);
        d.phase = SFR_H_CMD;
        d.tx    = {op, cmd_addr_i, cmd_mode_i};
        // RULE15: eight clocks of no valid instruction
        if (d.exitf) begin
          d.tx = {`SFR_OP_EXIT, 32'h0000_0000};
        // RULE13: continuous mode skips opcode
        end else if (cmd_skip_op_i) begin
          d.phase = SFR_H_ADDR;
          d.tx    = {cmd_addr_i, cmd_mode_i, 8'h00};
        end
        d.lane = {3'h0, d.tx[39]};
        d.oe_b = 4'hE;
        if (d.phase == SFR_H_ADDR) begin
          d.lane = {2'h0, d.tx[39:38]};
          d.oe_b = 4'hC;
        end
      end
    end else if (tick && q.sck) begin
      // Falling edge: new output bits
      d.sck = 1'b0;
      if (q.phase != SFR_H_DATA && q.phase != SFR_H_GAP) begin
        d.lane = dual_in ? {2'h0, q.tx[39:38]} : {3'h0, q.tx[39]};
        d.oe_b = dual_in ? 4'hC : 4'hE;
      end
    end else if (tick && q.phase == SFR_H_GAP) begin
      // RULE5: select high ends the command
      d.cs_b = 1'b1;
      d.gap  = q.gap + 2'h1;
      if (q.gap == `SFR_GAP_TICKS - 2'h1) begin
        d.gap   = 2'h0;
        d.phase = SFR_H_IDLE;
        d.ready = 1'b1;
      end
    end else if (tick) begin
      // Rising edge: device samples, host samples data
      d.sck = 1'b1;
      d.cnt = q.cnt + 5'h01;
      d.tx  = dual_in ? {q.tx[37:0], 2'h0} : {q.tx[38:0], 1'b0};
      unique case (q.phase)
        SFR_H_CMD: begin
          if (q.cnt == `SFR_CMD_CLKS - 5'h01) begin
            d.cnt   = 5'h00;
            d.phase = q.exitf ? SFR_H_GAP : SFR_H_ADDR;
          end
        end
        SFR_H_ADDR: begin
          // RULE11: two-lane address
          if (q.kind == SFR_K_DADDR && q.cnt == `SFR_ADDR2_CLKS - 5'h01) begin
            d.cnt   = 5'h00;
            d.phase = SFR_H_MODE;
          end else if (q.kind != SFR_K_DADDR && q.cnt == `SFR_ADDR1_CLKS - 5'h01) begin
            d.cnt   = 5'h00;
            d.phase = SFR_H_DUMMY;
          end
        end
        SFR_H_MODE: begin
          if (q.cnt == `SFR_MODE_CLKS - 5'h01) begin
            d.phase = SFR_H_DATA;
          end
        end
        SFR_H_DUMMY: begin
          if (q.cnt == `SFR_DUMMY_CLKS - 5'h01) begin
            d.phase = SFR_H_DATA;
          end
        end
        SFR_H_DATA: begin
          d.rx   = rxn;
          d.bits = bn;
          if (bn == 3'h0) begin
            d.push = 1'b1;
            d.pdat = rxn;
            d.left = q.left - 8'h01;
            if (q.left == 8'h01) begin
              d.phase = SFR_H_GAP;
            end
          end
        end
        default: begin
          d.phase = SFR_H_GAP;
        end
      endcase
      // RULE9: lanes released before first data fall
      if (d.phase == SFR_H_DATA || d.phase == SFR_H_GAP) begin
        d.oe_b = 4'hF;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      q <= HOST_RST;
    end else if (ce_i) begin
      q <= d;
    end
  end

  // ---------------------------------------------------------------
  // Receive buffer
  // ---------------------------------------------------------------
  sfr_fifo #(
    .WIDTH (`SFR_FIFO_WIDTH),
    .DEPTH (`SFR_FIFO_DEPTH)
  ) u_fifo (
    .clk_i       (clk_i),
    .rst_b_i     (rst_b_i),
    .ce_i        (ce_i),
    .in_valid_i  (q.push),
    .in_ready_o  (fifo_ready),
    .in_data_i   (q.pdat),
    .out_valid_o (rd_valid_o),
    .out_ready_i (rd_ready_i),
    .out_data_o  (rd_data_o)
  );

  assign link.sck            = q.sck;
  assign link.cs_b           = q.cs_b;
  assign link.host_lane      = q.lane;
  assign link.host_lane_oe_b = q.oe_b;
  assign cmd_ready_o         = q.ready;

endmodule

// [sim/sfr_link_chk.sv]
// Checker for the link between the host and device ends
`timescale 1ns/10ps
module sfr_link_chk (
  input wire logic       clk_i,             // System clock
  input wire logic       rst_b_i,           // Async reset
  input wire logic       sck_i,             // Link clock
  input wire logic       cs_b_i,            // Select
  input wire logic [3:0] host_lane_i,       // Host lane value
  input wire logic [3:0] host_lane_oe_b_i,  // Host lane enable
  input wire logic [3:0] dev_lane_i,        // Device lane value
  input wire logic [3:0] dev_lane_oe_b_i    // Device lane enable
);
  logic       sck_q;
  logic [4:0] rise_q;

  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  // ----
  // Rises per frame
  // ----
  // Saturates at the shortest header, no data can start earlier
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sck_q  <= 1'b0;
      rise_q <= 5'h00;
    end else begin
      sck_q <= sck_i;
      if (cs_b_i) begin
        rise_q <= 5'h00;
      end else if (sck_i && !sck_q && rise_q < 5'h10) begin
        rise_q <= rise_q + 5'h01;
      end
    end
  end

  chk_sck_idle_low: assert property (cs_b_i |-> !sck_i)
    else $error("link clock high while deselected");
  chk_lanes_released: assert property (cs_b_i |-> dev_lane_oe_b_i == 4'hF)
    else $error("device drives lanes while deselected");
  chk_no_contention: assert property ((~host_lane_oe_b_i & ~dev_lane_oe_b_i) == 4'h0)
    else $error("both ends drive one lane");
  chk_host_off_first: assert property (dev_lane_oe_b_i != 4'hF |-> host_lane_oe_b_i == 4'hF)
    else $error("host still drives during device output");
  chk_quiet_header: assert property (!cs_b_i && rise_q < 5'h10 |-> dev_lane_oe_b_i == 4'hF)
    else $error("device drives during the header");
  chk_lane_width: assert property (dev_lane_oe_b_i inside {4'hF, 4'hD, 4'hC, 4'h0})
    else $error("illegal set of driven lanes");
  chk_dev_on_fall: assert property (!cs_b_i && $past(!cs_b_i) && !$fell(sck_i)
    |-> $stable(dev_lane_i) && $stable(dev_lane_oe_b_i))
    else $error("device lanes changed off a falling edge");
  chk_host_on_fall: assert property (!cs_b_i && $past(!cs_b_i) && $changed(host_lane_i)
    |-> $fell(sck_i) || host_lane_oe_b_i == 4'hF)
    else $error("host lanes changed off a falling edge");
  chk_drive_holds: assert property (!cs_b_i && $past(!cs_b_i) && $past(dev_lane_oe_b_i) != 4'hF
    |-> dev_lane_oe_b_i == $past(dev_lane_oe_b_i))
    else $error("device output stopped inside a frame");

  cov_one_lane: cover property (dev_lane_oe_b_i == 4'hD);
  cov_two_lane: cover property (dev_lane_oe_b_i == 4'hC);
  cov_four_lane: cover property (dev_lane_oe_b_i == 4'h0);
endmodule

// [sim/tb.sv]
// Testbench joining the host and device ends over the link
`timescale 1ns/10ps
module tb;
  import sfr_pkg::*;
  logic         clk_i;
  logic         rst_b_i;
  logic         cmd_valid;
  logic         rd_ready;
  logic         busy;
  logic         wr_en;
  logic         skip;
  logic [7:0]   cfg;
  logic [7:0]   wr_addr;
  logic [7:0]   wr_data;
  logic [7:0]   mode;
  logic [7:0]   len;
  logic [7:0]   rd_data;
  logic [23:0]  addr;
  sfr_kind_type kind;
  logic         cmd_ready;
  logic         rd_valid;
  logic         cont;
  logic         ign;
  int           err_total = 0;
  int           tests_run = 0;
  int           cyc = 0;

  sfr_link_if link ();
  sfr_host sfr_host_i (.clk_i(clk_i), .rst_b_i(rst_b_i), .ce_i(1'b1), .link(link.host),
    .cmd_valid_i(cmd_valid), .cmd_ready_o(cmd_ready), .cmd_kind_i(kind), .cmd_addr_i(addr),
    .cmd_mode_i(mode), .cmd_skip_op_i(skip), .cmd_len_i(len), .rd_valid_o(rd_valid),
    .rd_ready_i(rd_ready), .rd_data_o(rd_data));
  sfr_dev sfr_dev_i (.link(link.device), .rst_b_i(rst_b_i), .ce_i(1'b1), .op_busy_i(busy),
    .config_reg_i(cfg), .wr_clk_i(clk_i), .wr_en_i(wr_en), .wr_addr_i(wr_addr),
    .wr_data_i(wr_data), .cont_mode_o(cont), .ignored_o(ign));
  sfr_link_chk sfr_link_chk_i (.clk_i(clk_i), .rst_b_i(rst_b_i), .sck_i(link.sck), .cs_b_i(link.cs_b),
    .host_lane_i(link.host_lane), .host_lane_oe_b_i(link.host_lane_oe_b), .dev_lane_i(link.dev_lane),
    .dev_lane_oe_b_i(link.dev_lane_oe_b));

  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  // ----
  // Tasks
  // ----
  task automatic end_of_test;
    $display("mismatches=%0d checks=%0d", err_total, tests_run);
    if (err_total == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic c8(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic c1(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic idle;
    do @(negedge clk_i); while (cmd_ready !== 1'b1);
  endtask

  task automatic run(input sfr_kind_type k, input logic [23:0] a, input logic [7:0] m,
                     input logic s, input logic [7:0] n);
    idle();
    @(posedge clk_i);
    cmd_valid <= 1'b1;
    kind <= k;
    addr <= a;
    mode <= m;
    skip <= s;
    len <= n;
    @(posedge clk_i);
    cmd_valid <= 1'b0;
  endtask

  // Array byte at address a is a ^ 5A, so a start of A5 expects all ones
  task automatic rd(input logic [7:0] a, input int n);
    for (int i = 0; i < n; i++) begin
      do @(negedge clk_i); while (rd_valid !== 1'b1);
      c8(rd_data, a + i[7:0] ^ 8'h5A);
      @(posedge clk_i);
    end
  endtask

  // Cuts a hang short
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 60000) begin
      err_total++;
      end_of_test();
    end
  end

  // ----
  // Sequence
  // ----
  initial begin
    cmd_valid = 1'b0;
    rd_ready = 1'b0;
    busy = 1'b0;
    wr_en = 1'b0;
    skip = 1'b0;
    cfg = 8'h00;
    wr_addr = 8'h00;
    wr_data = 8'h00;
    mode = 8'h00;
    len = 8'h00;
    addr = 24'h00_0000;
    kind = SFR_K_FAST;
    // Reset falls after time zero so no async reset misses the edge
    #1 rst_b_i = 1'b0;
    repeat (2) @(posedge clk_i);
    rst_b_i <= 1'b1;
    for (int i = 0; i < 256; i++) begin
      @(posedge clk_i);
      wr_en <= 1'b1;
      wr_addr <= i[7:0];
      wr_data <= i[7:0] ^ 8'h5A;
    end
    @(posedge clk_i);
    wr_en <= 1'b0;
    // More bytes than the FIFO holds, so the link must stall
    run(SFR_K_FAST, 24'h00_00F0, 8'h00, 1'b0, 8'h28);
    repeat (4000) @(negedge clk_i);
    c1(cmd_ready, 1'b0);
    @(posedge clk_i);
    rd_ready <= 1'b1;
    rd(8'hF0, 40);
    run(SFR_K_DOUT, 24'h00_0010, 8'h00, 1'b0, 8'h03);
    rd(8'h10, 3);
    run(SFR_K_QOUT, 24'h00_0020, 8'h00, 1'b0, 8'h01);
    rd(8'hA5, 1);
    idle();
    c1(ign, 1'b1);
    @(posedge clk_i);
    cfg <= 8'h02;
    run(SFR_K_QOUT, 24'h00_0020, 8'h00, 1'b0, 8'h02);
    rd(8'h20, 2);
    idle();
    c1(ign, 1'b0);
    @(posedge clk_i);
    busy <= 1'b1;
    run(SFR_K_FAST, 24'h00_0040, 8'h00, 1'b0, 8'h01);
    rd(8'hA5, 1);
    idle();
    c1(ign, 1'b1);
    @(posedge clk_i);
    busy <= 1'b0;
    run(SFR_K_DADDR, 24'h00_0050, 8'hA5, 1'b0, 8'h02);
    rd(8'h50, 2);
    idle();
    c1(cont, 1'b1);
    run(SFR_K_DADDR, 24'h00_0060, 8'h3C, 1'b1, 8'h02);
    rd(8'h60, 2);
    idle();
    c1(cont, 1'b0);
    run(SFR_K_DADDR, 24'h00_0070, 8'hA0, 1'b0, 8'h01);
    rd(8'h70, 1);
    idle();
    c1(cont, 1'b1);
    run(SFR_K_FAST, 24'h00_0000, 8'h00, 1'b1, 8'h01);
    run(SFR_K_FAST, 24'h00_0080, 8'h00, 1'b0, 8'h01);
    rd(8'h80, 1);
    idle();
    c1(cont, 1'b0);
    end_of_test();
  end
endmodule
